// ==== rtl/jtc_pkg.sv ====
// Package of the test access port controller: instruction codes,
// data path widths, controller states and timing figures.
// Assumes a single system clock that oversamples the test clock pin.
package jtc_pkg;

   // Instruction register
   localparam int IR_W = 3;
   localparam logic [2:0] IR_EXTEST = 3'h0;
   localparam logic [2:0] IR_SAMPLE = 3'h1;
   localparam logic [2:0] IR_DEBUG = 3'h2;
   localparam logic [2:0] IR_BYPASS = 3'h3;
   localparam logic [2:0] IR_PROG = 3'h4;
   localparam logic [2:0] IR_BYPASS_B = 3'h5;
   localparam logic [2:0] IR_RSVD = 3'h6;
   localparam logic [2:0] IR_BYPASS_C = 3'h7;
   localparam logic [2:0] IR_CAPTURE = 3'h1;
   localparam logic [2:0] IR_RESET = IR_BYPASS;

   // Data path widths
   localparam int DBG_W = 10;
   localparam int PRG_W = 3;

   // Pin reset levels: the pins idle high behind weak pull-ups
   localparam logic [2:0] PIN_RST = 3'h7;
   localparam logic TDO_IDLE = 1'b1;

   // Timing: test clock at most one eighth of the system clock
   localparam int CLK_PERIOD_NS = 20;
   localparam int TCK_RATIO = 8;
   localparam int TCK_MIN_HALF_CYC = (TCK_RATIO + 1) / 2;
   localparam int GAP_W = 4;
   localparam logic [3:0] GAP_MAX = 4'hF;

   // Controller states, Gray steps along the scan paths
   typedef enum logic [3:0] {
      ST_TLR = 4'h0,
      ST_RTI = 4'h1,
      ST_SEL_DR = 4'h3,
      ST_CAP_DR = 4'h2,
      ST_SH_DR = 4'h6,
      ST_EX1_DR = 4'h7,
      ST_UPD_DR = 4'h5,
      ST_PAUSE_DR = 4'h4,
      ST_EX2_DR = 4'hC,
      ST_SEL_IR = 4'hD,
      ST_CAP_IR = 4'hF,
      ST_SH_IR = 4'hE,
      ST_EX1_IR = 4'hA,
      ST_PAUSE_IR = 4'hB,
      ST_EX2_IR = 4'h9,
      ST_UPD_IR = 4'h8
   } jtc_state_t;

   // Selected data path between serial input and output
   typedef enum logic [1:0] {
      PATH_BYP = 2'h0,
      PATH_DBG = 2'h1,
      PATH_PRG = 2'h2
   } jtc_path_t;

endpackage : jtc_pkg

// ==== rtl/jtc_sync.sv ====
// Two-flop synchroniser for a group of single-bit levels.
// Assumes each bit is an independent level; no word coherence.
`timescale 1ns/1ns
`default_nettype none
module jtc_sync
   import jtc_pkg::*;
#(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r;

   // First flop feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RST;
         q <= RST;
      end else if (ce) begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule : jtc_sync
`default_nettype wire

// ==== rtl/jtc_dreg.sv ====
// Data shift register with its parallel buffer, one per private path.
// Assumes shift and update strobes are single-cycle, never together.
`timescale 1ns/1ns
`default_nettype none
module jtc_dreg
   import jtc_pkg::*;
#(
   parameter int W = DBG_W
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Strobes from the controller
   input wire logic shift_en,
   input wire logic update_en,
   input wire logic tdi,
   // Parallel side
   input wire logic [W-1:0] par_in,
   output logic [W-1:0] par_out,
   output logic upd_pulse,
   // Serial output bit
   output logic lsb
);

   logic [W-1:0] sh_r;

   // Shift toward the output, swap with buffers on update
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_r <= '0;
         par_out <= '0;
      end else if (ce) begin
         if (shift_en) begin
            sh_r <= {tdi, sh_r[W-1:1]};
         end else if (update_en) begin
            par_out <= sh_r;
            sh_r <= par_in;
         end
      end
   end

   // One-cycle notice that fresh data sits in the buffer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         upd_pulse <= 1'b0;
      end else if (ce) begin
         upd_pulse <= update_en;
      end
   end

   assign lsb = sh_r[0];

endmodule : jtc_dreg
`default_nettype wire

// ==== rtl/jtc_tap.sv ====
// Test access port controller: sixteen-state controller, 3-bit
// instruction register, bypass cell, debug and programming paths.
// Assumes the test clock pin is far slower than clk and is sampled.
`timescale 1ns/1ns
`default_nettype none
module jtc_tap
   import jtc_pkg::*;
(
   // System clock, reset, enable
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Test port pins
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   // Debug path parallel side
   input wire logic [DBG_W-1:0] dbg_tx_data,
   output logic [DBG_W-1:0] dbg_rx_data,
   output logic dbg_rx_valid,
   // Programming path parallel side
   input wire logic [PRG_W-1:0] prg_tx_data,
   output logic [PRG_W-1:0] prg_rx_data,
   output logic prg_rx_valid,
   // Controller status
   output logic [3:0] tap_state,
   output logic [IR_W-1:0] parallel_instruction_register,
   output logic path_debug,
   output logic path_prog,
   output logic tck_too_fast
);

   logic [1:0] rst_sync_r;
   logic rst_n;
   logic [2:0] pins_q;
   logic tck_q;
   logic tms_q;
   logic tdi_q;
   logic tck_d_r;
   logic tck_rise;
   logic tck_fall;
   jtc_state_t state_r;
   jtc_state_t state_nxt;
   logic [IR_W-1:0] ir_sh_r;
   logic [IR_W-1:0] ir_r;
   jtc_path_t path_r;
   jtc_path_t path_nxt;
   logic byp_r;
   logic in_sh_dr;
   logic in_sh_ir;
   logic dbg_shift;
   logic prg_shift;
   logic dbg_upd;
   logic prg_upd;
   logic dbg_lsb;
   logic prg_lsb;
   logic dr_lsb;
   logic tdo_r;
   logic tdo_oe_r;
   logic [GAP_W-1:0] gap_r;
   logic fast_r;

   // Reset release through two flops; assertion stays asynchronous
   // A release taken straight from the pin could meet clk mid-edge and
   // leave some flops in reset one cycle longer than others
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_r <= 2'h0;
      end else if (ce) begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // Pins come from the host's domain; pull-up levels at reset
   // All three pins share one latency, so mode select and serial input
   // stay lined up with the test clock edges that the edge finder sees
   jtc_sync #(
      .W(3),
      .RST(PIN_RST)
   ) u_pin_sync (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .d({tdi, tms, tck}),
      .q(pins_q)
   );
   assign tck_q = pins_q[0];
   assign tms_q = pins_q[1];
   assign tdi_q = pins_q[2];

   // Edge finder on the synchronised test clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tck_d_r <= PIN_RST[0];
      end else if (ce) begin
         tck_d_r <= tck_q;
      end
   end
   // No edges while the test clock stands still, so all holds except the speed watch gap count
   assign tck_rise = tck_q & ~tck_d_r;
   assign tck_fall = ~tck_q & tck_d_r;

   // Controller graph, mode select taken at each rising edge
   // Every state has a way back: mode select high reaches reset within
   // five edges, which recovers from any stray host activity
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_TLR: state_nxt = tms_q ? ST_TLR : ST_RTI;
         ST_RTI: state_nxt = tms_q ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: state_nxt = tms_q ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: state_nxt = tms_q ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: state_nxt = tms_q ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: state_nxt = tms_q ? ST_UPD_DR : ST_PAUSE_DR;
         ST_PAUSE_DR: state_nxt = tms_q ? ST_EX2_DR : ST_PAUSE_DR;
         ST_EX2_DR: state_nxt = tms_q ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: state_nxt = tms_q ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: state_nxt = tms_q ? ST_TLR : ST_CAP_IR;
         ST_CAP_IR: state_nxt = tms_q ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: state_nxt = tms_q ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: state_nxt = tms_q ? ST_UPD_IR : ST_PAUSE_IR;
         ST_PAUSE_IR: state_nxt = tms_q ? ST_EX2_IR : ST_PAUSE_IR;
         ST_EX2_IR: state_nxt = tms_q ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: state_nxt = tms_q ? ST_SEL_DR : ST_RTI;
         default: state_nxt = ST_TLR;
      endcase
   end

   // State advances only on a rising test clock edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_TLR;
      end else if (ce && tck_rise) begin
         state_r <= state_nxt;
      end
   end

   assign in_sh_dr = (state_r == ST_SH_DR);
   assign in_sh_ir = (state_r == ST_SH_IR);

   // Instruction shift register: capture and shift on rising edges
   // Contents do not matter outside the instruction scan, so they hold
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ir_sh_r <= IR_CAPTURE;
      end else if (ce && tck_rise) begin
         if (state_r == ST_CAP_IR) begin
            ir_sh_r <= IR_CAPTURE;
         end else if (in_sh_ir) begin
            ir_sh_r <= {tdi_q, ir_sh_r[IR_W-1:1]};
         end
      end
   end

   // Parallel instruction: bypass in reset, load at update falling edge
   // Data-scan states never reach this register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ir_r <= IR_RESET;
      end else if (ce) begin
         if (state_r == ST_TLR) begin
            ir_r <= IR_RESET;
         end else if (tck_fall && state_r == ST_UPD_IR) begin
            ir_r <= ir_sh_r;
         end
      end
   end

   // Path decode of the instruction about to be loaded
   // Decoding the shift register, not the loaded copy, lets path and
   // instruction change on the same update edge
   always_comb begin
      path_nxt = path_r;
      case (ir_sh_r)
         IR_EXTEST: path_nxt = path_r;
         IR_SAMPLE: path_nxt = path_r;
         IR_DEBUG: path_nxt = PATH_DBG;
         IR_PROG: path_nxt = PATH_PRG;
         IR_BYPASS: path_nxt = PATH_BYP;
         IR_BYPASS_B: path_nxt = PATH_BYP;
         IR_BYPASS_C: path_nxt = PATH_BYP;
         // Reserved code has no path; keeping the old one is the safe guess
         IR_RSVD: path_nxt = path_r;
         default: path_nxt = path_r;
      endcase
   end

   // Selected path follows the instruction update; reset picks bypass
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         path_r <= PATH_BYP;
      end else if (ce) begin
         if (state_r == ST_TLR) begin
            path_r <= PATH_BYP;
         end else if (tck_fall && state_r == ST_UPD_IR) begin
            path_r <= path_nxt;
         end
      end
   end

   // Bypass cell: zero on capture, one cell of delay while shifting
   // Capturing zero lets the host count cells in an unknown chain
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         byp_r <= 1'b0;
      end else if (ce && tck_rise) begin
         if (state_r == ST_CAP_DR) begin
            byp_r <= 1'b0;
         end else if (in_sh_dr && path_r == PATH_BYP) begin
            byp_r <= tdi_q;
         end
      end
   end

   // Strobes for the private paths
   // Shift and update never coincide, as they need different states
   assign dbg_shift = tck_rise && in_sh_dr && path_r == PATH_DBG;
   assign prg_shift = tck_rise && in_sh_dr && path_r == PATH_PRG;
   assign dbg_upd = tck_fall && state_r == ST_UPD_DR && path_r == PATH_DBG;
   assign prg_upd = tck_fall && state_r == ST_UPD_DR && path_r == PATH_PRG;

   // Debug path, 10 bits
   jtc_dreg #(
      .W(DBG_W)
   ) u_dbg (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .shift_en(dbg_shift),
      .update_en(dbg_upd),
      .tdi(tdi_q),
      .par_in(dbg_tx_data),
      .par_out(dbg_rx_data),
      .upd_pulse(dbg_rx_valid),
      .lsb(dbg_lsb)
   );

   // Programming path, 3 bits
   jtc_dreg #(
      .W(PRG_W)
   ) u_prg (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .shift_en(prg_shift),
      .update_en(prg_upd),
      .tdi(tdi_q),
      .par_in(prg_tx_data),
      .par_out(prg_rx_data),
      .upd_pulse(prg_rx_valid),
      .lsb(prg_lsb)
   );

   // Output bit of the selected data path
   always_comb begin
      case (path_r)
         PATH_DBG: dr_lsb = dbg_lsb;
         PATH_PRG: dr_lsb = prg_lsb;
         default: dr_lsb = byp_r;
      endcase
   end

   // Serial output moves only on falling edges, driven in shift states
   // Launching on the fall gives the host, sampling on its rise, a bit
   // that has settled for a whole half period
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tdo_r <= TDO_IDLE;
         tdo_oe_r <= 1'b0;
      end else if (ce && tck_fall) begin
         if (in_sh_ir) begin
            tdo_r <= ir_sh_r[0];
            tdo_oe_r <= 1'b1;
         end else if (in_sh_dr) begin
            tdo_r <= dr_lsb;
            tdo_oe_r <= 1'b1;
         end else begin
            tdo_r <= TDO_IDLE;
            tdo_oe_r <= 1'b0;
         end
      end
   end

   // Test clock speed watch: a half period shorter than allowed is
   // flagged and held until reset, since sampled edges may be lost
   // Limitation: the flag only warns; a scan under way may be garbled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_r <= GAP_MAX;
         fast_r <= 1'b0;
      end else if (ce) begin
         if (tck_rise || tck_fall) begin
            gap_r <= '0;
            if (gap_r < GAP_W'(TCK_MIN_HALF_CYC - 1)) begin
               fast_r <= 1'b1;
            end
         end else if (gap_r != GAP_MAX) begin
            gap_r <= gap_r + 1'b1;
         end
      end
   end

   // Status outputs
   assign tdo = tdo_r;
   assign tdo_oe = tdo_oe_r;
   assign tap_state = state_r;
   assign parallel_instruction_register = ir_r;
   assign path_debug = (path_r == PATH_DBG);
   assign path_prog = (path_r == PATH_PRG);
   assign tck_too_fast = fast_r;

endmodule : jtc_tap
`default_nettype wire

// ==== test/jtc_tap_assertions.sv ====
// Checker of the test port controller, bound to its top module.
// Assumes ce held high and a test clock far slower than clk.
`timescale 1ns/1ns
`default_nettype none
module jtc_tap_assertions
   import jtc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Pins
   input wire logic tck,
   input wire logic tdo,
   input wire logic tdo_oe,
   // Parallel sides
   input wire logic [DBG_W-1:0] dbg_rx_data,
   input wire logic dbg_rx_valid,
   input wire logic [PRG_W-1:0] prg_rx_data,
   input wire logic prg_rx_valid,
   // Status
   input wire logic [3:0] tap_state,
   input wire logic [IR_W-1:0] parallel_instruction_register,
   input wire logic path_debug,
   input wire logic path_prog
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // Short alias for the instruction
   logic [IR_W-1:0] pir;
   assign pir = parallel_instruction_register;

   a_tlr_bypass: assert property (tap_state == ST_TLR |=> pir == IR_RESET)
      else $error("instruction not bypass in reset state");
   a_ir_holds: assert property ($changed(pir) |-> tap_state == ST_TLR || $past(tap_state) == ST_UPD_IR)
      else $error("instruction changed outside update");
   a_idle_tdo: assert property (!tdo_oe |-> tdo == TDO_IDLE)
      else $error("serial output not idle");
   a_oe_shift: assert property ($rose(tdo_oe) |-> tap_state inside {ST_SH_IR, ST_SH_DR})
      else $error("output enabled outside shift");
   // Pin latency is a few clk, so look two samples back
   a_tdo_fall: assert property (($changed(tdo) || $changed(tdo_oe)) |-> !$past(tck, 2))
      else $error("serial output moved off falling edge");
   a_state_rise: assert property ($changed(tap_state) |-> $past(tck, 2))
      else $error("state moved without rising edge");
   a_path_decode: assert property (($changed(path_debug) || $changed(path_prog)) |->
      path_debug == (pir == IR_DEBUG) && path_prog == (pir == IR_PROG))
      else $error("path does not match instruction");
   a_dbg_valid: assert property (dbg_rx_valid |-> tap_state == ST_UPD_DR && path_debug ##1 !dbg_rx_valid)
      else $error("debug valid pulse misplaced");
   // Buffer and valid pulse are loaded by the same clk edge
   a_dbg_rx_load: assert property ($changed(dbg_rx_data) |-> dbg_rx_valid)
      else $error("debug buffer load without valid");
   a_prg_rx_load: assert property ($changed(prg_rx_data) |-> path_prog && prg_rx_valid)
      else $error("program buffer load misplaced");
endmodule : jtc_tap_assertions

bind jtc_tap jtc_tap_assertions i_jtc_tap_assertions (.clk, .rstn, .tck, .tdo, .tdo_oe, .dbg_rx_data,
   .dbg_rx_valid, .prg_rx_data, .prg_rx_valid, .tap_state, .parallel_instruction_register, .path_debug,
   .path_prog);
`default_nettype wire

// ==== test/jtc_host_model.sv ====
// Host model driving the test port pins through scan sequences.
// Assumes calls start 1 ns after a clk edge; 160 ns test clock.
`timescale 1ns/1ns
`default_nettype none
module jtc_host_model (
   // Pins toward the port
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   // Pins idle high as the pull-ups leave them
   initial begin
      tck = 1'b1;
      tms = 1'b1;
      tdi = 1'b1;
   end

   // One period, low half first; output taken late in high half
   task automatic step(input logic m, input logic d, output logic o);
      tck = 1'b0;
      tms = m;
      tdi = d;
      #80;
      tck = 1'b1;
      #80;
      o = tdo;
   endtask : step

   // Five high mode cycles force the reset state from anywhere
   task automatic reset5;
      logic o;
      repeat (5) step(1'b1, 1'b1, o);
   endtask : reset5

   // Short test clock pulse with mode select high, for the speed watch
   task automatic pulse(input int half_ns);
      tck = 1'b0;
      tms = 1'b1;
      #(half_ns);
      tck = 1'b1;
      #(half_ns);
   endtask : pulse

   // Scan from idle or reset: instruction (ir high) or data, n bits LSB first
   task automatic scan(input logic ir, input int n, input logic [9:0] din, output logic [9:0] dout);
      logic o;
      dout = 10'h0;
      step(1'b0, 1'b1, o);
      step(1'b1, 1'b1, o);
      if (ir) step(1'b1, 1'b1, o);
      step(1'b0, 1'b1, o);
      step(1'b0, 1'b1, o);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], o);
         dout[i] = o;
      end
      step(1'b1, 1'b1, o);
      step(1'b0, 1'b1, o); // never sent reserved code
   endtask : scan
endmodule : jtc_host_model
`default_nettype wire

// ==== test/tb_jtag_tap_controller.sv ====
// Self-checking bench of the test port controller.
// Assumes the host model drives pins; parallel data from the bench.
`timescale 1ns/1ns
`default_nettype none
module tb_jtag_tap_controller
   import jtc_pkg::*;
;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic tck, tms, tdi, tdo, tdo_oe, dbg_rx_valid, prg_rx_valid, path_debug, path_prog, tck_too_fast, o;
   logic [DBG_W-1:0] dbg_tx_data = 10'h0, dbg_rx_data, d;
   logic [PRG_W-1:0] prg_tx_data = 3'h0, prg_rx_data;
   logic [3:0] tap_state;
   logic [IR_W-1:0] pir;
   int fails = 0;
   int check_count = 0;
   int dbg_valid_n = 0;
   int prg_valid_n = 0;

   always #10 clk = ~clk;

   // Buffer valid pulses, counted away from the launching edge
   always @(negedge clk) begin
      if (dbg_rx_valid === 1'b1) begin
         dbg_valid_n++;
      end
      if (prg_rx_valid === 1'b1) begin
         prg_valid_n++;
      end
   end

   jtc_tap i_jtc_tap (.clk(clk), .rstn(rstn), .ce(1'b1), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdo_oe(tdo_oe), .dbg_tx_data(dbg_tx_data), .dbg_rx_data(dbg_rx_data), .dbg_rx_valid(dbg_rx_valid),
      .prg_tx_data(prg_tx_data), .prg_rx_data(prg_rx_data), .prg_rx_valid(prg_rx_valid),
      .tap_state(tap_state), .parallel_instruction_register(pir), .path_debug(path_debug),
      .path_prog(path_prog), .tck_too_fast(tck_too_fast));

   jtc_host_model i_jtc_host_model (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic wrap_up;
      if (fails == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up

   // State lags the pin by a few clk
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask : settle

   task automatic load_ir(input logic [2:0] c);
      i_jtc_host_model.scan(1'b1, 3, {7'h0, c}, d);
      chk(d, 10'h1);
      chk(10'(pir), 10'(c));
   endtask : load_ir

   task automatic t_reset;
      chk(10'(tap_state), 10'(ST_TLR));
      chk(10'(pir), 10'(IR_RESET));
      chk(10'({tdo_oe, path_debug, path_prog}), 10'h0);
   endtask : t_reset

   task automatic t_debug;
      load_ir(IR_DEBUG);
      chk(10'(path_debug), 10'h1);
      dbg_tx_data = 10'h2A5;
      i_jtc_host_model.scan(1'b0, DBG_W, 10'h135, d);
      chk(dbg_rx_data, 10'h135);
      i_jtc_host_model.scan(1'b0, DBG_W, 10'h0CA, d);
      chk(d, 10'h2A5);
      chk(dbg_rx_data, 10'h0CA);
      chk(10'(pir), 10'(IR_DEBUG));
      chk(10'(dbg_valid_n), 10'h2);
   endtask : t_debug

   task automatic t_prog;
      load_ir(IR_PROG);
      chk(10'({path_debug, path_prog}), 10'h1);
      prg_tx_data = 3'h6;
      i_jtc_host_model.scan(1'b0, PRG_W, 10'h5, d);
      chk(10'(prg_rx_data), 10'h5);
      i_jtc_host_model.scan(1'b0, PRG_W, 10'h3, d);
      chk(d, 10'h6);
      chk(10'(prg_rx_data), 10'h3);
      chk(10'(prg_valid_n), 10'h2);
   endtask : t_prog

   // No-op codes leave the programming path in place
   task automatic t_nop;
      load_ir(IR_EXTEST);
      chk(10'(path_prog), 10'h1);
      load_ir(IR_SAMPLE);
      chk(10'(path_prog), 10'h1);
   endtask : t_nop

   // Bypass cell captures 0, so two bits come back as 0 then tdi
   task automatic t_bypass;
      logic [2:0] c [3] = '{IR_BYPASS, IR_BYPASS_B, IR_BYPASS_C};
      foreach (c[i]) begin
         load_ir(c[i]);
         chk(10'({path_debug, path_prog}), 10'h0);
         i_jtc_host_model.scan(1'b0, 2, 10'h1, d);
         chk(d, 10'h2);
      end
      chk(10'(dbg_valid_n + prg_valid_n), 10'h4);
   endtask : t_bypass

   task automatic t_tlr;
      load_ir(IR_DEBUG);
      repeat (3) i_jtc_host_model.step(1'b1, 1'b1, o);
      settle();
      chk(10'(tap_state), 10'(ST_TLR));
      chk(10'({pir, path_debug}), 10'({IR_RESET, 1'b0}));
      i_jtc_host_model.step(1'b1, 1'b1, o);
      settle();
      chk(10'(tap_state), 10'(ST_TLR));
      i_jtc_host_model.step(1'b0, 1'b1, o);
      i_jtc_host_model.step(1'b1, 1'b1, o);
      i_jtc_host_model.step(1'b0, 1'b1, o);
      i_jtc_host_model.step(1'b0, 1'b1, o);
      settle();
      chk(10'(tap_state), 10'(ST_SH_DR));
      i_jtc_host_model.reset5();
      settle();
      chk(10'(tap_state), 10'(ST_TLR));
      chk(10'(tck_too_fast), 10'h0);
   endtask : t_tlr

   // Too short test clock halves set the sticky flag; a mid-run reset
   // clears it and the port works again afterwards
   task automatic t_fast;
      repeat (2) i_jtc_host_model.pulse(40);
      settle();
      chk(10'(tck_too_fast), 10'h1);
      chk(10'(tap_state), 10'(ST_TLR));
      rstn = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      rstn = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(10'({tck_too_fast, tdo_oe, path_debug, path_prog}), 10'h0);
      chk(dbg_rx_data, 10'h0);
      chk(10'(pir), 10'(IR_RESET));
      repeat (6) @(posedge clk);
      #1;
      load_ir(IR_PROG);
      chk(10'(path_prog), 10'h1);
   endtask : t_fast

   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      #1;
      rstn = 1'b1;
      repeat (8) @(posedge clk);
      #1;
      t_reset();
      t_debug();
      t_prog();
      t_nop();
      t_bypass();
      t_tlr();
      t_fast();
      wrap_up();
   end

   // Watchdog, well past the expected run
   initial begin
      #300000;
      fails++;
      wrap_up();
   end
endmodule : tb_jtag_tap_controller
`default_nettype wire
